// File: common/drapr_pkg.sv
// Package for the reference A profile register bank of the first digital loop.
// Assumes byte-wide registers at their printed byte offsets on a plain port.
package drapr_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_REGS = 13;
  localparam int unsigned IDX_W = 4;
  // Register byte offsets
  localparam logic [11:0] OFS_PRIO_EN = 12'h440;
  localparam logic [11:0] OFS_BW_LOW = 12'h441;
  localparam logic [11:0] OFS_BW_MID = 12'h442;
  localparam logic [11:0] OFS_BW_HIGH_FILT = 12'h443;
  localparam logic [11:0] OFS_DIV_LOW = 12'h444;
  localparam logic [11:0] OFS_DIV_MID = 12'h445;
  localparam logic [11:0] OFS_DIV_HIGH = 12'h446;
  localparam logic [11:0] OFS_NUM_LOW = 12'h447;
  localparam logic [11:0] OFS_NUM_MID = 12'h448;
  localparam logic [11:0] OFS_NUM_HIGH = 12'h449;
  localparam logic [11:0] OFS_MOD_LOW = 12'h44A;
  localparam logic [11:0] OFS_MOD_MID = 12'h44B;
  localparam logic [11:0] OFS_MOD_HIGH = 12'h44C;
  // Register indices inside the bank
  localparam logic [3:0] IDX_PRIO_EN = 4'h0;
  localparam logic [3:0] IDX_BW_LOW = 4'h1;
  localparam logic [3:0] IDX_BW_MID = 4'h2;
  localparam logic [3:0] IDX_BW_HIGH_FILT = 4'h3;
  localparam logic [3:0] IDX_DIV_LOW = 4'h4;
  localparam logic [3:0] IDX_DIV_MID = 4'h5;
  localparam logic [3:0] IDX_DIV_HIGH = 4'h6;
  localparam logic [3:0] IDX_NUM_LOW = 4'h7;
  localparam logic [3:0] IDX_NUM_MID = 4'h8;
  localparam logic [3:0] IDX_NUM_HIGH = 4'h9;
  localparam logic [3:0] IDX_MOD_LOW = 4'hA;
  localparam logic [3:0] IDX_MOD_MID = 4'hB;
  localparam logic [3:0] IDX_MOD_HIGH = 4'hC;
  // Writable bits per register; all others are reserved and read zero
  localparam logic [7:0] MASK_PRIO_EN = 8'h07;
  localparam logic [7:0] MASK_BW_HIGH_FILT = 8'h03;
  localparam logic [7:0] MASK_DIV_HIGH = 8'h03;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [7:0] UNMAPPED_VAL = 8'h00;
  // Field positions
  localparam int unsigned EN_BIT = 0;
  localparam int unsigned PRIO_LSB = 1;
  localparam int unsigned PRIO_W = 2;
  localparam int unsigned BW_MSB_BIT = 0;
  localparam int unsigned FILT_BIT = 1;
  localparam int unsigned BW_W = 17;
  localparam int unsigned DIV_W = 18;
  localparam int unsigned DIV_HI_W = 2;
  localparam int unsigned FRAC_W = 24;
  localparam int unsigned RATIO_W = 19;
  localparam logic [23:0] FRAC_ZERO = 24'h000000;
  localparam logic [18:0] RATIO_ONE = 19'h00001;
  localparam logic [1:0] RANK_BEST = 2'h0;
  // Loop use state
  typedef enum logic [1:0] {
    DRAPR_IDLE = 2'b00,
    DRAPR_ARMED = 2'b01,
    DRAPR_ACTIVE = 2'b10
  } drapr_use_e;
endpackage : drapr_pkg

// File: logic/drapr_mem.sv
// Small byte register array with per-entry write masks and registered read.
// Assumes one write port and one read port on the same clock.
`timescale 1ns/1ps
module drapr_mem
  import drapr_pkg::*;
(
  // Clock and control
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Write port
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [DATA_W-1:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [DATA_W-1:0] rd_data,
  // Flat view of all entries for the field decode
  output logic [NUM_REGS*DATA_W-1:0] all_regs
);

  logic [DATA_W-1:0] mem_reg [NUM_REGS];

  // Reserved bits are masked on write so they stay zero forever
  function automatic logic [DATA_W-1:0] drapr_mask(input logic [IDX_W-1:0] idx);
    unique case (idx)
      IDX_PRIO_EN: drapr_mask = MASK_PRIO_EN;
      IDX_BW_HIGH_FILT: drapr_mask = MASK_BW_HIGH_FILT;
      IDX_DIV_HIGH: drapr_mask = MASK_DIV_HIGH;
      default: drapr_mask = MASK_FULL;
    endcase
  endfunction : drapr_mask

  // Storage; every entry clears to zero at reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        mem_reg[i] <= RESET_VAL;
      end
    end else if (clk_en && wr_en) begin
      mem_reg[wr_idx] <= wr_data & drapr_mask(wr_idx);
    end
  end

  // Registered read data
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data <= RESET_VAL;
    end else if (clk_en && rd_en) begin
      rd_data <= mem_reg[rd_idx];
    end
  end

  // Flat export
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      all_regs[i*DATA_W +: DATA_W] = mem_reg[i];
    end
  end

endmodule : drapr_mem

// File: logic/drapr_regs.sv
// Reference A profile register bank of the first digital loop and its field decode.
// Assumes a plain same-clock register port and a loop controller that reads the fields.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
// Functional notes
// - Two-bit rank for reference A; code 0 is highest, 3 lowest.
// - Loop may lock to reference A only while the permit bit is set.
// - Seventeen-bit bandwidth factor in 0.1 Hz from two bytes plus one bit.
// - Filter bit picks normal 70 degree margin or high margin filter.
// - Eighteen-bit divider field; divide ratio is field plus one.
// - Twenty-four-bit fraction numerator, low byte at lowest offset.
// - Twenty-four-bit fraction modulus, low byte at lowest offset.
// - Zero modulus bypasses the fractional divider, integer only.
// - Bandwidth, divider and reserved bits reset to zero.
module drapr_regs
  import drapr_pkg::*;
(
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Reference selection inputs from the monitors
  input wire logic ref_a_valid,
  input wire logic other_ref_avail,
  input wire logic [PRIO_W-1:0] other_ref_rank,
  // Profile fields to the loop
  output logic ref_a_lock_permit,
  output logic [PRIO_W-1:0] ref_a_select_rank,
  output logic [BW_W-1:0] loop_bw_factor,
  output logic high_margin_filter,
  output logic [DIV_W-1:0] integer_feedback_divisor,
  output logic [RATIO_W-1:0] divide_ratio,
  output logic [FRAC_W-1:0] fraction_numerator,
  output logic [FRAC_W-1:0] fraction_modulus,
  output logic frac_bypass,
  // Selection result
  output logic ref_a_selected,
  output logic profile_active
);

  logic [NUM_REGS*DATA_W-1:0] all_regs;
  logic [DATA_W-1:0] mem_rdata;
  logic wr_hit;
  logic rd_hit;
  logic [IDX_W-1:0] wr_idx;
  logic [IDX_W-1:0] rd_idx;
  logic rd_hit_reg;
  logic [DATA_W-1:0] prio_byte_c;
  logic [DATA_W-1:0] bw_filt_byte_c;
  logic [DATA_W-1:0] div_high_byte_c;
  drapr_use_e use_reg;
  drapr_use_e use_next;
  logic [PRIO_W-1:0] rank_c;
  logic permit_c;
  logic [BW_W-1:0] bw_c;
  logic filt_c;
  logic [DIV_W-1:0] div_c;
  logic [FRAC_W-1:0] num_c;
  logic [FRAC_W-1:0] mod_c;
  logic pick_a_c;

  // Address to bank index; flags a mapped byte
  function automatic logic drapr_decode(input logic [ADDR_W-1:0] addr,
                                        output logic [IDX_W-1:0] idx);
    logic [ADDR_W-1:0] rel;
    rel = addr - OFS_PRIO_EN;
    idx = rel[IDX_W-1:0];
    drapr_decode = (addr >= OFS_PRIO_EN) && (addr <= OFS_MOD_HIGH);
  endfunction : drapr_decode

  // Byte of the flat register image
  function automatic logic [DATA_W-1:0] drapr_byte(input logic [NUM_REGS*DATA_W-1:0] img,
                                                   input logic [IDX_W-1:0] idx);
    drapr_byte = img[idx*DATA_W +: DATA_W];
  endfunction : drapr_byte

  // Strobe decode
  always_comb begin
    // Decode first so the index is assigned on every path, never latched
    wr_hit = drapr_decode(reg_addr, wr_idx) && reg_wr;
    rd_hit = drapr_decode(reg_addr, rd_idx) && reg_rd;
  end

  drapr_mem u_mem (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .wr_en(wr_hit),
    .wr_idx(wr_idx),
    .wr_data(reg_wdata),
    .rd_en(rd_hit),
    .rd_idx(rd_idx),
    .rd_data(mem_rdata),
    .all_regs(all_regs)
  );

  // Remember whether last read hit the bank, for the read path cross-check
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_hit_reg <= 1'b0;
    end else if (clk_en) begin
      rd_hit_reg <= rd_hit;
    end
  end

  // Read data stand only in the cycle after the strobe; unmapped reads answer zero.
  // Taken from the byte image so the port comes straight from a flop with no extra
  // cycle; the memory's own registered read only backs a cross-check.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= UNMAPPED_VAL;
    end else if (clk_en) begin
      reg_rdata <= rd_hit ? drapr_byte(all_regs, rd_idx) : UNMAPPED_VAL;
    end
  end

  // Field assembly from the byte image
  always_comb begin
    prio_byte_c = drapr_byte(all_regs, IDX_PRIO_EN);
    bw_filt_byte_c = drapr_byte(all_regs, IDX_BW_HIGH_FILT);
    div_high_byte_c = drapr_byte(all_regs, IDX_DIV_HIGH);
    rank_c = prio_byte_c[PRIO_LSB +: PRIO_W];
    permit_c = prio_byte_c[EN_BIT];
    bw_c = {bw_filt_byte_c[BW_MSB_BIT],
            drapr_byte(all_regs, IDX_BW_MID),
            drapr_byte(all_regs, IDX_BW_LOW)};
    filt_c = bw_filt_byte_c[FILT_BIT];
    div_c = {div_high_byte_c[DIV_HI_W-1:0],
             drapr_byte(all_regs, IDX_DIV_MID),
             drapr_byte(all_regs, IDX_DIV_LOW)};
    num_c = {drapr_byte(all_regs, IDX_NUM_HIGH),
             drapr_byte(all_regs, IDX_NUM_MID),
             drapr_byte(all_regs, IDX_NUM_LOW)};
    mod_c = {drapr_byte(all_regs, IDX_MOD_HIGH),
             drapr_byte(all_regs, IDX_MOD_MID),
             drapr_byte(all_regs, IDX_MOD_LOW)};
  end

  // Ties go to reference A, since a lower code only wins when strictly lower
  always_comb begin
    pick_a_c = permit_c && ref_a_valid &&
               (!other_ref_avail || (rank_c <= other_ref_rank));
  end

  // Registered field outputs for the loop; one cycle behind the bank
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ref_a_select_rank <= RANK_BEST;
      ref_a_lock_permit <= 1'b0;
      loop_bw_factor <= '0;
      high_margin_filter <= 1'b0;
      integer_feedback_divisor <= '0;
      divide_ratio <= RATIO_ONE;
      fraction_numerator <= FRAC_ZERO;
      fraction_modulus <= FRAC_ZERO;
      frac_bypass <= 1'b1;
    end else if (clk_en) begin
      ref_a_select_rank <= rank_c;
      ref_a_lock_permit <= permit_c;
      loop_bw_factor <= bw_c;
      high_margin_filter <= filt_c;
      integer_feedback_divisor <= div_c;
      divide_ratio <= {1'b0, div_c} + RATIO_ONE;
      fraction_numerator <= num_c;
      fraction_modulus <= mod_c;
      frac_bypass <= (mod_c == FRAC_ZERO);
    end
  end

  // Use state: armed when chosen, active one cycle later while still chosen
  always_comb begin
    use_next = use_reg;
    unique case (use_reg)
      DRAPR_IDLE: if (pick_a_c) use_next = DRAPR_ARMED;
      DRAPR_ARMED: use_next = pick_a_c ? DRAPR_ACTIVE : DRAPR_IDLE;
      DRAPR_ACTIVE: if (!pick_a_c) use_next = DRAPR_IDLE;
      default: use_next = DRAPR_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      use_reg <= DRAPR_IDLE;
    end else if (clk_en) begin
      use_reg <= use_next;
    end
  end

  // Selection outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ref_a_selected <= 1'b0;
      profile_active <= 1'b0;
    end else if (clk_en) begin
      ref_a_selected <= pick_a_c;
      profile_active <= (use_next == DRAPR_ACTIVE);
    end
  end

  // Checks
  property p_bypass;
    @(posedge ref_clk) disable iff (rst)
      clk_en |=> (frac_bypass == ($past(mod_c) == FRAC_ZERO));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass mismatch");

  property p_ratio;
    @(posedge ref_clk) disable iff (rst)
      divide_ratio == {1'b0, integer_feedback_divisor} + RATIO_ONE;
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio not field plus one");

  property p_permit;
    @(posedge ref_clk) disable iff (rst)
      ref_a_selected |-> $past(permit_c);
  endproperty
  a_permit: assert property (p_permit) else $error("selected without permit");

  property p_bw_write;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && reg_wr && reg_addr == OFS_BW_LOW) ##1 clk_en |=>
        loop_bw_factor[DATA_W-1:0] == $past(reg_wdata, 2);
  endproperty
  a_bw_write: assert property (p_bw_write) else $error("bw low byte lost");

  property p_filt;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && reg_wr && reg_addr == OFS_BW_HIGH_FILT) ##1 clk_en |=>
        high_margin_filter == $past(reg_wdata[FILT_BIT], 2);
  endproperty
  a_filt: assert property (p_filt) else $error("filter bit lost");

  property p_num_high;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && reg_wr && reg_addr == OFS_NUM_HIGH) ##1 clk_en |=>
        fraction_numerator[FRAC_W-1 -: DATA_W] == $past(reg_wdata, 2);
  endproperty
  a_num_high: assert property (p_num_high) else $error("numerator msb lost");

  property p_mod_low;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && reg_wr && reg_addr == OFS_MOD_LOW) ##1 clk_en |=>
        fraction_modulus[DATA_W-1:0] == $past(reg_wdata, 2);
  endproperty
  a_mod_low: assert property (p_mod_low) else $error("modulus lsb lost");

  property p_reserved;
    @(posedge ref_clk) disable iff (rst)
      $past(clk_en) && rd_hit_reg && $past(reg_addr) == OFS_PRIO_EN |->
        reg_rdata[DATA_W-1:PRIO_LSB+PRIO_W] == '0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_rank;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && permit_c && ref_a_valid && other_ref_avail &&
       other_ref_rank < rank_c) |=> !ref_a_selected;
  endproperty
  a_rank: assert property (p_rank) else $error("worse rank selected");

  property p_rd_path;
    @(posedge ref_clk) disable iff (rst)
      rd_hit_reg |-> reg_rdata == mem_rdata;
  endproperty
  a_rd_path: assert property (p_rd_path) else $error("read paths disagree");

  property p_div_high;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && reg_wr && reg_addr == OFS_DIV_HIGH) ##1 clk_en |=>
        integer_feedback_divisor[DIV_W-1 -: DIV_HI_W] == $past(reg_wdata[DIV_HI_W-1:0], 2);
  endproperty
  a_div_high: assert property (p_div_high) else $error("divider msbs lost");

  property p_bw_msb;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && reg_wr && reg_addr == OFS_BW_HIGH_FILT) ##1 clk_en |=>
        loop_bw_factor[BW_W-1] == $past(reg_wdata[BW_MSB_BIT], 2);
  endproperty
  a_bw_msb: assert property (p_bw_msb) else $error("bw msb lost");

  property p_mod_high;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && reg_wr && reg_addr == OFS_MOD_HIGH) ##1 clk_en |=>
        fraction_modulus[FRAC_W-1 -: DATA_W] == $past(reg_wdata, 2);
  endproperty
  a_mod_high: assert property (p_mod_high) else $error("modulus msb lost");

  property p_rank_out;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && reg_wr && reg_addr == OFS_PRIO_EN) ##1 clk_en |=>
        ref_a_select_rank == $past(reg_wdata[PRIO_LSB +: PRIO_W], 2);
  endproperty
  a_rank_out: assert property (p_rank_out) else $error("rank field lost");

  property p_active;
    @(posedge ref_clk) disable iff (rst)
      profile_active |-> ref_a_selected;
  endproperty
  a_active: assert property (p_active) else $error("profile active while not chosen");

  property p_lone;
    @(posedge ref_clk) disable iff (rst)
      (clk_en && permit_c && ref_a_valid && !other_ref_avail) |=> ref_a_selected;
  endproperty
  a_lone: assert property (p_lone) else $error("lone reference not chosen");

endmodule : drapr_regs

// File: tb/drapr_regs_tb.sv
// Self-checking bench for the reference A profile register bank.
// Assumes drapr_pkg and the drapr_regs design are compiled first.
`timescale 1ns/1ps
module drapr_regs_tb;
  import drapr_pkg::*;
  // Design inputs
  logic ref_clk, rst, clk_en, reg_wr, reg_rd, ref_a_valid, other_ref_avail;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic [PRIO_W-1:0] other_ref_rank;
  // Design outputs
  logic [DATA_W-1:0] reg_rdata;
  logic ref_a_lock_permit, high_margin_filter, frac_bypass, ref_a_selected, profile_active;
  logic [PRIO_W-1:0] ref_a_select_rank;
  logic [BW_W-1:0] loop_bw_factor;
  logic [DIV_W-1:0] integer_feedback_divisor;
  logic [RATIO_W-1:0] divide_ratio;
  logic [FRAC_W-1:0] fraction_numerator, fraction_modulus;
  int n_mismatch = 0;
  int n_tests = 0;

  drapr_regs dut_u (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ref_a_valid(ref_a_valid), .other_ref_avail(other_ref_avail),
    .other_ref_rank(other_ref_rank), .ref_a_lock_permit(ref_a_lock_permit),
    .ref_a_select_rank(ref_a_select_rank), .loop_bw_factor(loop_bw_factor),
    .high_margin_filter(high_margin_filter),
    .integer_feedback_divisor(integer_feedback_divisor), .divide_ratio(divide_ratio),
    .fraction_numerator(fraction_numerator), .fraction_modulus(fraction_modulus),
    .frac_bypass(frac_bypass), .ref_a_selected(ref_a_selected),
    .profile_active(profile_active));

  // Free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One-cycle write strobe, launched and dropped right after edges
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe, zero after that
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk($sformatf("rdata %h", a), {24'h0, exp}, {24'h0, reg_rdata});
    @(posedge ref_clk);
    #1 chk("rdata idle", 32'h0, {24'h0, reg_rdata});
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle

  // Field outputs in one call, given as expected values
  task automatic fields(input logic [16:0] bw, input logic filt, input logic [17:0] dv,
                        input logic [23:0] num, input logic [23:0] md);
    settle(2);
    chk("bw", {15'h0, bw}, {15'h0, loop_bw_factor});
    chk("filter", {31'h0, filt}, {31'h0, high_margin_filter});
    chk("divisor", {14'h0, dv}, {14'h0, integer_feedback_divisor});
    chk("ratio", 32'(dv) + 32'h1, {13'h0, divide_ratio});
    chk("numerator", {8'h0, num}, {8'h0, fraction_numerator});
    chk("modulus", {8'h0, md}, {8'h0, fraction_modulus});
    chk("bypass", {31'h0, md == FRAC_ZERO}, {31'h0, frac_bypass});
  endtask : fields

  task automatic t_reset;
    for (int i = 0; i < NUM_REGS; i++) rd(12'(OFS_PRIO_EN + i), RESET_VAL);
    fields(17'h0, 1'b0, 18'h0, 24'h0, 24'h0);
    chk("permit", 32'h0, {31'h0, ref_a_lock_permit});
  endtask : t_reset

  // All ones everywhere; reserved bits and unmapped places stay zero
  task automatic t_masks;
    logic [7:0] m;
    for (int i = 0; i < NUM_REGS; i++) wr(12'(OFS_PRIO_EN + i), 8'hFF);
    wr(12'h44D, 8'hFF);
    wr(12'h43F, 8'hFF);
    for (int i = 0; i < NUM_REGS; i++) begin
      m = (i == 0) ? 8'h07 : ((i == 3 || i == 6) ? 8'h03 : 8'hFF);
      rd(12'(OFS_PRIO_EN + i), m);
    end
    rd(12'h44D, 8'h00);
    rd(12'h43F, 8'h00);
    fields(17'h1FFFF, 1'b1, 18'h3FFFF, 24'hFFFFFF, 24'hFFFFFF);
    chk("rank", 32'h3, {30'h0, ref_a_select_rank});
    chk("permit", 32'h1, {31'h0, ref_a_lock_permit});
  endtask : t_masks

  // Distinct bytes show byte order; 0x443 reserved bits set, bit 16 alone kept
  task automatic t_fields;
    logic [7:0] v [13] = '{8'h05, 8'h34, 8'h12, 8'hFD, 8'h78, 8'h56, 8'hFE,
                           8'hAB, 8'hCD, 8'hEF, 8'h01, 8'h00, 8'h00};
    for (int i = 0; i < NUM_REGS; i++) wr(12'(OFS_PRIO_EN + i), v[i]);
    fields(17'h11234, 1'b0, 18'h25678, 24'hEFCDAB, 24'h000001);
    wr(OFS_BW_HIGH_FILT, 8'h02);
    wr(OFS_MOD_LOW, 8'h00);
    wr(OFS_MOD_HIGH, 8'h80);
    fields(17'h01234, 1'b1, 18'h25678, 24'hEFCDAB, 24'h800000);
    wr(OFS_MOD_HIGH, 8'h00);
    fields(17'h01234, 1'b1, 18'h25678, 24'hEFCDAB, 24'h000000);
  endtask : t_fields

  // Rank against another reference of rank 2, then permit, validity, no rival
  task automatic sel(input logic [7:0] pe, input logic v, input logic oa, input logic e);
    wr(OFS_PRIO_EN, pe);
    ref_a_valid <= v;
    other_ref_avail <= oa;
    settle(4);
    chk($sformatf("selected %h", pe), {31'h0, e}, {31'h0, ref_a_selected});
    chk("active", {31'h0, e}, {31'h0, profile_active});
  endtask : sel

  task automatic t_select;
    @(posedge ref_clk);
    other_ref_rank <= 2'h2;
    for (int r = 0; r < 4; r++) begin
      sel(8'(r * 2 + 1), 1'b1, 1'b1, r <= 2);
      chk("rank", 32'(r), {30'h0, ref_a_select_rank});
    end
    sel(8'h00, 1'b1, 1'b0, 1'b0);
    sel(8'h07, 1'b0, 1'b0, 1'b0);
    sel(8'h07, 1'b1, 1'b0, 1'b1);
  endtask : t_select

  // Strobe ignored while frozen, then a reset in mid-run clears the bank
  task automatic t_freeze_reset;
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(OFS_NUM_LOW, 8'h55);
    clk_en <= 1'b1;
    rd(OFS_NUM_LOW, 8'hAB);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(OFS_NUM_LOW, 8'h00);
    fields(17'h0, 1'b0, 18'h0, 24'h0, 24'h0);
    chk("selected after reset", 32'h0, {31'h0, ref_a_selected});
  endtask : t_freeze_reset

  task automatic final_report;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    ref_a_valid = 1'b0;
    other_ref_avail = 1'b0;
    other_ref_rank = '0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_masks();
    t_fields();
    t_select();
    t_freeze_reset();
    final_report();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
endmodule : drapr_regs_tb
